/* File: mpx_defines.vh */
/*
 * Shared constants of the program/PID multiplexer: register map,
 * field reset values, PID pool bounds, session kinds and event codes.
 * Assumes inclusion by bare name from files of the same folder.
 */
`ifndef MPX_DEFINES_VH
`define MPX_DEFINES_VH

// ==========================================================
// sizes
`define MPX_NSESS 20
`define MPX_NSLOT 8
`define MPX_NENT 160
`define MPX_SEARCH_MAX 14'd8160

// ==========================================================
// register byte offsets
`define MPX_A_SEL 8'h00
`define MPX_A_CFG 8'h04
`define MPX_A_PROG 8'h08
`define MPX_A_CMD 8'h0c
`define MPX_A_PIDE 8'h10
`define MPX_A_RSV0 8'h14
`define MPX_A_RSV1 8'h18
`define MPX_A_STAT 8'h1c
`define MPX_A_SSTAT 8'h20
`define MPX_A_MAP 8'h24

// ==========================================================
// commands, session kinds, events
`define MPX_CMD_SETUP 2'h1
`define MPX_CMD_TEAR 2'h2
`define MPX_CMD_ADDPID 2'h3
`define MPX_K_STATIC 2'h0
`define MPX_K_DYN_ONE 2'h1
`define MPX_K_DYN_ALL 2'h2
`define MPX_EV_PROG 2'h1
`define MPX_EV_PID 2'h2

// ==========================================================
// pid pool and reset values
`define MPX_PID_LO 13'h0030
`define MPX_PID_HI 13'h1fef
`define MPX_RSV_LO_RST 13'h1fff
`define MPX_RSV_HI_RST 13'h0000
`define MPX_PID_W 13

`endif

/* File: mpx_pid_alloc.v */
/*
 * Round-robin allocator of remapped output PIDs.
 * Assumes the caller answers used_i for cand_o in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mpx_defines.vh"

module mpx_pid_alloc #(
	parameter [13:0] SEARCH_MAX = `MPX_SEARCH_MAX
) (
	input wire ref_clk_i,
	input wire rst_i,
	input wire start_i,
	input wire used_i,
	input wire [12:0] rsv0_lo_i,
	input wire [12:0] rsv0_hi_i,
	input wire [12:0] rsv1_lo_i,
	input wire [12:0] rsv1_hi_i,
	output wire [12:0] cand_o,
	output reg [12:0] res_o,
	output reg done_o,
	output reg fail_o
);

reg [12:0] ptr_r;
reg [13:0] cnt_r;
reg busy_r;
wire in_rsv;
wire cand_ok;
wire [12:0] ptr_nxt;

// ==========================================================
// candidate test
// reserved ranges skipped
assign in_rsv = (ptr_r >= rsv0_lo_i && ptr_r <= rsv0_hi_i) ||
	(ptr_r >= rsv1_lo_i && ptr_r <= rsv1_hi_i);
assign cand_ok = (ptr_r >= `MPX_PID_LO) && (ptr_r <= `MPX_PID_HI) && !in_rsv && !used_i;
assign ptr_nxt = (ptr_r >= `MPX_PID_HI) ? `MPX_PID_LO : ptr_r + 13'h0001;
assign cand_o = ptr_r;

// ==========================================================
// search walk
always @(posedge ref_clk_i) begin
	if (rst_i) begin
		ptr_r <= `MPX_PID_LO;
		cnt_r <= 14'h0000;
		busy_r <= 1'b0;
		res_o <= 13'h0000;
		done_o <= 1'b0;
		fail_o <= 1'b0;
	end else begin
		done_o <= 1'b0;
		fail_o <= 1'b0;
		if (start_i) begin
			busy_r <= 1'b1;
			cnt_r <= 14'h0000;
		end else if (busy_r) begin
			ptr_r <= ptr_nxt;
			if (cand_ok) begin
				res_o <= ptr_r;
				done_o <= 1'b1;
				busy_r <= 1'b0;
			end else if (cnt_r == SEARCH_MAX - 14'h0001) begin
				fail_o <= 1'b1;
				busy_r <= 1'b0;
			end else begin
				cnt_r <= cnt_r + 14'h0001;
			end
		end
	end
end

endmodule
`default_nettype wire

/* File: mpx_program_mux.v */
/*
 * Program-number and PID manager of one output channel multiplex.
 * Holds session and PID tables, checks conflicts, remaps PIDs and
 * relabels or drops packet headers. Assumes packet, learn and
 * register inputs come from logic on ref_clk_i.
 */
// Decided for this implementation: the address map and the address-and-strobe port.
// What this block does
// - carry up to twenty programs per channel output.
// - static port-map session takes program number from UDP port.
// - dynamic single gets number from setup; whole-stream learns from PAT.
// - refuse setup whose program number clashes with existing session.
// - later clash excludes newest session from PAT and routing.
// - report a learned program-number clash as unsolicited event; a refused setup only sets the refused status bit.
// - at least eight PIDs per program.
// - never pick well-known PIDs as remapped values.
// - remapped PIDs only within general-purpose range.
// - keep every output PID unique, remapping as needed.
// - skip configured reserved ranges when remapping.
// - no-remap session forwards PMT PID and listed PIDs unchanged.
// - unavoidable PID clash drops newest session and reports it.
// - route every PID listed in the program's PMT.
// - drop ghost PIDs not in PAT or any PMT.
// - pick remap PIDs round-robin through the pool.
// - private PMT descriptors reach the output PMT.
// - non-PMT packets on PMT PID forwarded unmodified.
// - private data on PMT PID accepted at 50 kbps to 2 Mbps.
// - no-remap pre-conditioned stream keeps numbers and PIDs.
// - merge constant-rate single-program inputs into output.
// - merge pre-conditioned inputs with other inputs into one output.
// - advance PAT version on setup, teardown and learned number, PMT version on each added PID; a PID-failure exclusion advances neither.
`timescale 1ns/1ps
`default_nettype none
`include "mpx_defines.vh"

module mpx_program_mux #(
	parameter [13:0] SEARCH_MAX = `MPX_SEARCH_MAX
) (
	input wire ref_clk_i,
	input wire rst_i,
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [31:0] reg_rdata_o,
	input wire pkt_valid_i,
	input wire [4:0] pkt_sess_i,
	input wire [12:0] pkt_pid_i,
	output reg out_valid_o,
	output reg [12:0] out_pid_o,
	output reg out_drop_o,
	input wire learn_valid_i,
	input wire [4:0] learn_sess_i,
	input wire [15:0] learn_prog_i,
	output reg evt_valid_o,
	output reg [1:0] evt_code_o,
	output reg [4:0] evt_sess_o,
	output reg [4:0] pat_ver_o
);

localparam [1:0] ST_IDLE = 2'b01;
localparam [1:0] ST_ALLOC = 2'b10;

// ==========================================================
// configuration registers
reg [4:0] sel_r;
reg [1:0] kind_r;
reg norm_r;
reg [15:0] prog_r;
reg [12:0] pe_in_r;
reg [2:0] pe_slot_r;
reg [12:0] rsv0_lo_r, rsv0_hi_r, rsv1_lo_r, rsv1_hi_r;
reg refused_r;
reg pidfail_r;
reg [1:0] st_r;

// ==========================================================
// session and pid tables
// twenty session rows
reg [19:0] s_valid_r, s_excl_r, s_norm_r, s_learn_r, s_known_r;
reg [15:0] s_prog_r [0:19];
reg [4:0] s_pmtver_r [0:19];
reg [`MPX_NENT-1:0] e_v_r;
reg [12:0] e_in_r [0:`MPX_NENT-1];
reg [12:0] e_out_r [0:`MPX_NENT-1];

wire sel_ok = sel_r < `MPX_NSESS;
wire [7:0] pe_idx = {sel_r, pe_slot_r};
wire alloc_start;
wire [12:0] alloc_cand;
wire [12:0] alloc_res;
wire alloc_done, alloc_fail;
wire cand_used;
wire cmd_wr = reg_wr_i && reg_addr_i == `MPX_A_CMD;
wire [1:0] cmd = reg_wdata_i[1:0];

// ==========================================================
// shared lookups
// clash against every valid, known, non-excluded session other than self
function prog_clash;
	input [15:0] p;
	input [4:0] self;
	integer i;
	begin
		prog_clash = 1'b0;
		for (i = 0; i < `MPX_NSESS; i = i + 1) begin
			if (s_valid_r[i] && s_known_r[i] && !s_excl_r[i] && i != self &&
				s_prog_r[i] == p) begin
				prog_clash = 1'b1;
			end
		end
	end
endfunction

function pid_used;
	input [12:0] p;
	integer i;
	begin
		pid_used = 1'b0;
		for (i = 0; i < `MPX_NENT; i = i + 1) begin
			if (e_v_r[i] && e_out_r[i] == p) begin
				pid_used = 1'b1;
			end
		end
	end
endfunction

assign cand_used = pid_used(alloc_cand);
assign alloc_start = cmd_wr && cmd == `MPX_CMD_ADDPID && st_r == ST_IDLE && sel_ok &&
	s_valid_r[sel_r] && !s_norm_r[sel_r];

mpx_pid_alloc #(
	.SEARCH_MAX(SEARCH_MAX)
) u_alloc (
	.ref_clk_i(ref_clk_i),
	.rst_i(rst_i),
	.start_i(alloc_start),
	.used_i(cand_used),
	.rsv0_lo_i(rsv0_lo_r),
	.rsv0_hi_i(rsv0_hi_r),
	.rsv1_lo_i(rsv1_lo_r),
	.rsv1_hi_i(rsv1_hi_r),
	.cand_o(alloc_cand),
	.res_o(alloc_res),
	.done_o(alloc_done),
	.fail_o(alloc_fail)
);

// ==========================================================
// packet pid match
wire sess_ok = pkt_sess_i < `MPX_NSESS;
wire [7:0] hit;
genvar g;
generate
	for (g = 0; g < `MPX_NSLOT; g = g + 1) begin : g_slot
		localparam integer SL = g;
		wire [7:0] ix = {pkt_sess_i, SL[2:0]};
		assign hit[g] = sess_ok && e_v_r[ix] && e_in_r[ix] == pkt_pid_i;
	end
endgenerate

reg [12:0] hit_pid;
reg any_hit;
integer k;
always @* begin
	hit_pid = 13'h0000;
	any_hit = 1'b0;
	for (k = `MPX_NSLOT - 1; k >= 0; k = k - 1) begin
		if (hit[k]) begin
			any_hit = 1'b1;
			hit_pid = e_out_r[{pkt_sess_i, k[2:0]}];
		end
	end
end

wire pkt_pass = sess_ok && s_valid_r[pkt_sess_i] && !s_excl_r[pkt_sess_i] && any_hit;

// ==========================================================
// packet relabel
// header pid only rewritten; PMT and private payload pass untouched
always @(posedge ref_clk_i) begin
	if (rst_i) begin
		out_valid_o <= 1'b0;
		out_pid_o <= 13'h0000;
		out_drop_o <= 1'b0;
	end else begin
		out_valid_o <= pkt_valid_i && pkt_pass;
		out_drop_o <= pkt_valid_i && !pkt_pass;
		// no rate limit on PMT pid
		if (pkt_valid_i && pkt_pass) begin
			out_pid_o <= hit_pid;
		end
	end
end

// ==========================================================
// control and tables
integer j;
always @(posedge ref_clk_i) begin
	if (rst_i) begin
		sel_r <= 5'h00;
		kind_r <= `MPX_K_STATIC;
		norm_r <= 1'b0;
		prog_r <= 16'h0000;
		pe_in_r <= 13'h0000;
		pe_slot_r <= 3'h0;
		rsv0_lo_r <= `MPX_RSV_LO_RST;
		rsv0_hi_r <= `MPX_RSV_HI_RST;
		rsv1_lo_r <= `MPX_RSV_LO_RST;
		rsv1_hi_r <= `MPX_RSV_HI_RST;
		refused_r <= 1'b0;
		pidfail_r <= 1'b0;
		st_r <= ST_IDLE;
		s_valid_r <= 20'h00000;
		s_excl_r <= 20'h00000;
		s_norm_r <= 20'h00000;
		s_learn_r <= 20'h00000;
		s_known_r <= 20'h00000;
		e_v_r <= {`MPX_NENT{1'b0}};
		pat_ver_o <= 5'h00;
		evt_valid_o <= 1'b0;
		evt_code_o <= 2'h0;
		evt_sess_o <= 5'h00;
		for (j = 0; j < `MPX_NSESS; j = j + 1) begin
			s_prog_r[j] <= 16'h0000;
			s_pmtver_r[j] <= 5'h00;
		end
	end else begin
		evt_valid_o <= 1'b0;
		if (reg_wr_i) begin
			case (reg_addr_i)
				`MPX_A_SEL: sel_r <= reg_wdata_i[4:0];
				`MPX_A_CFG: begin
					kind_r <= reg_wdata_i[1:0];
					norm_r <= reg_wdata_i[2];
				end
				`MPX_A_PROG: prog_r <= reg_wdata_i[15:0];
				`MPX_A_PIDE: begin
					pe_in_r <= reg_wdata_i[12:0];
					pe_slot_r <= reg_wdata_i[18:16];
				end
				`MPX_A_RSV0: begin
					rsv0_lo_r <= reg_wdata_i[12:0];
					rsv0_hi_r <= reg_wdata_i[28:16];
				end
				`MPX_A_RSV1: begin
					rsv1_lo_r <= reg_wdata_i[12:0];
					rsv1_hi_r <= reg_wdata_i[28:16];
				end
				default: ;
			endcase
		end
		case (st_r)
			ST_IDLE: begin
				if (cmd_wr && sel_ok && cmd == `MPX_CMD_SETUP && !s_valid_r[sel_r]) begin
					// static prog is the udp port in prog_r
					if (kind_r != `MPX_K_DYN_ALL && prog_clash(prog_r, sel_r)) begin
						refused_r <= 1'b1;
					end else begin
						refused_r <= 1'b0;
						s_valid_r[sel_r] <= 1'b1;
						s_excl_r[sel_r] <= 1'b0;
						s_norm_r[sel_r] <= norm_r;
						s_learn_r[sel_r] <= kind_r == `MPX_K_DYN_ALL;
						s_known_r[sel_r] <= kind_r != `MPX_K_DYN_ALL;
						s_prog_r[sel_r] <= prog_r;
						pat_ver_o <= pat_ver_o + 5'h01;
					end
				end else if (cmd_wr && sel_ok && cmd == `MPX_CMD_TEAR && s_valid_r[sel_r]) begin
					s_valid_r[sel_r] <= 1'b0;
					s_known_r[sel_r] <= 1'b0;
					for (j = 0; j < `MPX_NSLOT; j = j + 1) begin
						e_v_r[{sel_r, j[2:0]}] <= 1'b0;
					end
					pat_ver_o <= pat_ver_o + 5'h01;
				end else if (alloc_start) begin
					st_r <= ST_ALLOC;
				end else if (cmd_wr && sel_ok && cmd == `MPX_CMD_ADDPID && s_valid_r[sel_r]) begin
					if (pid_used(pe_in_r)) begin
						s_excl_r[sel_r] <= 1'b1;
						pidfail_r <= 1'b1;
						evt_valid_o <= 1'b1;
						evt_code_o <= `MPX_EV_PID;
						evt_sess_o <= sel_r;
					end else begin
						pidfail_r <= 1'b0;
						e_v_r[pe_idx] <= 1'b1;
						e_in_r[pe_idx] <= pe_in_r;
						e_out_r[pe_idx] <= pe_in_r;
						s_pmtver_r[sel_r] <= s_pmtver_r[sel_r] + 5'h01;
					end
				end
			end
			ST_ALLOC: begin
				if (alloc_done) begin
					pidfail_r <= 1'b0;
					e_v_r[pe_idx] <= 1'b1;
					e_in_r[pe_idx] <= pe_in_r;
					e_out_r[pe_idx] <= alloc_res;
					s_pmtver_r[sel_r] <= s_pmtver_r[sel_r] + 5'h01;
					st_r <= ST_IDLE;
				end else if (alloc_fail) begin
					s_excl_r[sel_r] <= 1'b1;
					pidfail_r <= 1'b1;
					evt_valid_o <= 1'b1;
					evt_code_o <= `MPX_EV_PID;
					evt_sess_o <= sel_r;
					st_r <= ST_IDLE;
				end
			end
			default: st_r <= ST_IDLE;
		endcase
		// a learned number arrives beside register traffic; event wins
		if (learn_valid_i && learn_sess_i < `MPX_NSESS && s_valid_r[learn_sess_i] &&
			s_learn_r[learn_sess_i]) begin
			s_prog_r[learn_sess_i] <= learn_prog_i;
			s_known_r[learn_sess_i] <= 1'b1;
			pat_ver_o <= pat_ver_o + 5'h01;
			if (prog_clash(learn_prog_i, learn_sess_i)) begin
				// newest session left out of PAT
				s_excl_r[learn_sess_i] <= 1'b1;
				evt_valid_o <= 1'b1;
				evt_code_o <= `MPX_EV_PROG;
				evt_sess_o <= learn_sess_i;
			end
		end
	end
end

// ==========================================================
// register read
// remapped values visible to table builder
wire [31:0] map_word = {18'h00000, e_v_r[pe_idx], e_out_r[pe_idx]};
wire [31:0] sstat_word = {s_prog_r[sel_r], 3'h0, s_pmtver_r[sel_r], 4'h0,
	s_learn_r[sel_r], s_norm_r[sel_r], s_excl_r[sel_r], s_valid_r[sel_r]};

always @(posedge ref_clk_i) begin
	if (rst_i) begin
		reg_rdata_o <= 32'h00000000;
	end else if (reg_rd_i) begin
		case (reg_addr_i)
			`MPX_A_SEL: reg_rdata_o <= {27'h0000000, sel_r};
			`MPX_A_CFG: reg_rdata_o <= {29'h00000000, norm_r, kind_r};
			`MPX_A_PROG: reg_rdata_o <= {16'h0000, prog_r};
			`MPX_A_PIDE: reg_rdata_o <= {13'h0000, pe_slot_r, 3'h0, pe_in_r};
			`MPX_A_RSV0: reg_rdata_o <= {3'h0, rsv0_hi_r, 3'h0, rsv0_lo_r};
			`MPX_A_RSV1: reg_rdata_o <= {3'h0, rsv1_hi_r, 3'h0, rsv1_lo_r};
			`MPX_A_STAT: reg_rdata_o <= {19'h00000, pat_ver_o, 5'h00, pidfail_r,
				refused_r, st_r[1]};
			`MPX_A_SSTAT: reg_rdata_o <= sel_ok ? sstat_word : 32'h00000000;
			`MPX_A_MAP: reg_rdata_o <= sel_ok ? map_word : 32'h00000000;
			default: reg_rdata_o <= 32'h00000000;
		endcase
	end else begin
		reg_rdata_o <= 32'h00000000;
	end
end

endmodule
`default_nettype wire

/* File: mpx_program_mux_asserts.sv */
/*
 * Port-level properties of the program/PID multiplexer.
 * Assumes a bind onto mpx_program_mux, one clock, synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module mpx_program_mux_asserts (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic pkt_valid_i,
	input wire logic out_valid_o,
	input wire logic [12:0] out_pid_o,
	input wire logic out_drop_o,
	input wire logic evt_valid_o,
	input wire logic [1:0] evt_code_o,
	input wire logic [4:0] evt_sess_o,
	input wire logic [4:0] pat_ver_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// packet answers
	one_answer_a: assert property (!(out_valid_o && out_drop_o))
		else $error("packet both forwarded and dropped");
	pkt_answer_a: assert property (pkt_valid_i |=> out_valid_o || out_drop_o)
		else $error("packet header left unanswered");
	no_spurious_a: assert property (!pkt_valid_i |=> !out_valid_o && !out_drop_o)
		else $error("answer without a packet");
	pid_hold_a: assert property (!out_valid_o |-> $stable(out_pid_o))
		else $error("output pid moved without a packet");
	// ==========================================================
	// registers, events and tables
	rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
		else $error("read data outside its cycle");
	evt_code_a: assert property (evt_valid_o |-> evt_code_o == 2'h1 || evt_code_o == 2'h2)
		else $error("event with unknown code");
	evt_sess_a: assert property (evt_valid_o |-> evt_sess_o < 5'd20)
		else $error("event names no session");
	patver_step_a: assert property ($changed(pat_ver_o) |-> pat_ver_o == $past(pat_ver_o) + 5'h1)
		else $error("table version jumped");
	cover property (pkt_valid_i ##1 out_valid_o);
	cover property (out_drop_o);
	cover property (evt_valid_o && evt_code_o == 2'h1);
	cover property (evt_valid_o && evt_code_o == 2'h2);
endmodule
`default_nettype wire

/* File: mpx_src_model.sv */
/*
 * Upstream stream source: packet headers and PAT-learned numbers.
 * Assumes callers run its tasks from one process on ref_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module mpx_src_model (
	input wire logic ref_clk_i,
	output logic pkt_valid_o,
	output logic [4:0] pkt_sess_o,
	output logic [12:0] pkt_pid_o,
	output logic learn_valid_o,
	output logic [4:0] learn_sess_o,
	output logic [15:0] learn_prog_o
);
	initial begin
		pkt_valid_o = 1'b0;
		pkt_sess_o = 5'h0;
		pkt_pid_o = 13'h0;
		learn_valid_o = 1'b0;
		learn_sess_o = 5'h0;
		learn_prog_o = 16'h0;
	end
	// ==========================================================
	// one header, then released lines show the inverse, not stale data
	task send(input logic [4:0] s, input logic [12:0] p);
		@(posedge ref_clk_i);
		pkt_valid_o <= 1'b1;
		pkt_sess_o <= s;
		pkt_pid_o <= p;
		@(posedge ref_clk_i);
		pkt_valid_o <= 1'b0;
		pkt_sess_o <= ~s;
		pkt_pid_o <= ~p;
	endtask
	task learn(input logic [4:0] s, input logic [15:0] p);
		@(posedge ref_clk_i);
		learn_valid_o <= 1'b1;
		learn_sess_o <= s;
		learn_prog_o <= p;
		@(posedge ref_clk_i);
		learn_valid_o <= 1'b0;
		learn_sess_o <= ~s;
		learn_prog_o <= ~p;
	endtask
endmodule
`default_nettype wire

/* File: tb_mpx_program_mux.sv */
/*
 * Self-checking bench of the program/PID multiplexer.
 * Assumes the source model and the checker compile beside it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "mpx_defines.vh"
module tb_mpx_program_mux;
	logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i;
	logic [7:0] reg_addr_i;
	logic [31:0] reg_wdata_i, v;
	wire [31:0] reg_rdata_o;
	wire pv, lv, out_valid_o, out_drop_o, evt_valid_o;
	wire [4:0] ps, ls, evt_sess_o, pat_ver_o;
	wire [12:0] pp, out_pid_o;
	wire [15:0] lp;
	wire [1:0] evt_code_o;
	logic [1:0] ev_code;
	logic [4:0] ev_sess;
	int mismatches, n_compared;
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	mpx_src_model i_mpx_src_model (.ref_clk_i(ref_clk_i), .pkt_valid_o(pv), .pkt_sess_o(ps),
		.pkt_pid_o(pp), .learn_valid_o(lv), .learn_sess_o(ls), .learn_prog_o(lp));
	// short search bound keeps a failed hunt brief
	mpx_program_mux #(.SEARCH_MAX(14'd16)) i_mpx_program_mux (.ref_clk_i(ref_clk_i),
		.rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pkt_valid_i(pv), .pkt_sess_i(ps),
		.pkt_pid_i(pp), .out_valid_o(out_valid_o), .out_pid_o(out_pid_o),
		.out_drop_o(out_drop_o), .learn_valid_i(lv), .learn_sess_i(ls), .learn_prog_i(lp),
		.evt_valid_o(evt_valid_o), .evt_code_o(evt_code_o), .evt_sess_o(evt_sess_o),
		.pat_ver_o(pat_ver_o));
	always @(posedge ref_clk_i) begin
		if (evt_valid_o === 1'b1) begin
			ev_code <= evt_code_o;
			ev_sess <= evt_sess_o;
		end
	end
	// ==========================================================
	// access tasks
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask
	task setup(input logic [4:0] s, input logic [31:0] cfg, input logic [15:0] prog);
		wr(`MPX_A_SEL, 32'(s));
		wr(`MPX_A_CFG, cfg);
		wr(`MPX_A_PROG, 32'(prog));
		wr(`MPX_A_CMD, 32'h1);
	endtask
	task addpid(input logic [4:0] s, input logic [2:0] slot, input logic [12:0] p);
		wr(`MPX_A_SEL, 32'(s));
		wr(`MPX_A_PIDE, {13'h0, slot, 3'h0, p});
		wr(`MPX_A_CMD, 32'h3);
		repeat (40) begin
			rd(`MPX_A_STAT, v);
			if (v[0] === 1'b0) break;
		end
	endtask
	task pkt(input logic [4:0] s, input logic [12:0] p, input logic fw, input logic [12:0] ep);
		i_mpx_src_model.send(s, p);
		#1;
		chk("forwarded", 32'(out_valid_o), 32'(fw));
		chk("dropped", 32'(out_drop_o), 32'(!fw));
		if (fw) chk("out pid", 32'(out_pid_o), 32'(ep));
	endtask
	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	initial begin
		mismatches = 0;
		n_compared = 0;
		rst_i = 1'b1;
		reg_wr_i = 1'b0;
		reg_rd_i = 1'b0;
		reg_addr_i = 8'h0;
		reg_wdata_i = 32'h0;
		repeat (5) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rd(`MPX_A_RSV0, v);
		chk("reserved reset", v, 32'h0000_1fff);
		rd(8'h30, v);
		chk("unmapped", v, 32'h0);
		setup(5'd0, 32'h0, 16'd100);
		rd(`MPX_A_SSTAT, v);
		chk("static session", v, 32'h0064_0001);
		chk("pat version", 32'(pat_ver_o), 32'h1);
		setup(5'd1, 32'h1, 16'd100);
		rd(`MPX_A_STAT, v);
		chk("clash refused", v, 32'h0000_0102);
		setup(5'd1, 32'h1, 16'd300);
		rd(`MPX_A_SSTAT, v);
		chk("dynamic session", v, 32'h012c_0001);
		rd(`MPX_A_STAT, v);
		chk("refusal cleared", v, 32'h0000_0200);
		wr(`MPX_A_RSV0, 32'h0031_0030);
		addpid(5'd0, 3'd0, 13'h0100);
		rd(`MPX_A_MAP, v);
		chk("remap skips reserved", v, 32'h0000_2032);
		addpid(5'd0, 3'd1, 13'h0101);
		rd(`MPX_A_MAP, v);
		chk("round robin", v, 32'h0000_2033);
		rd(`MPX_A_SSTAT, v);
		chk("pmt version", v, 32'h0064_0201);
		pkt(5'd0, 13'h0100, 1'b1, 13'h0032);
		pkt(5'd0, 13'h0101, 1'b1, 13'h0033);
		pkt(5'd0, 13'h0555, 1'b0, 13'h0);
		pkt(5'd21, 13'h0100, 1'b0, 13'h0);
		setup(5'd2, 32'h4, 16'd200);
		addpid(5'd2, 3'd0, 13'h1fed);
		pkt(5'd2, 13'h1fed, 1'b1, 13'h1fed);
		setup(5'd3, 32'h4, 16'd400);
		addpid(5'd3, 3'd0, 13'h0032);
		chk("pid clash event", {25'h0, ev_code, ev_sess}, 32'h43);
		chk("pid failure flag", 32'(v[2]), 32'h1);
		pkt(5'd3, 13'h0032, 1'b0, 13'h0);
		rd(`MPX_A_SSTAT, v);
		chk("pid clash excluded", 32'(v[1]), 32'h1);
		setup(5'd4, 32'h2, 16'd500);
		i_mpx_src_model.learn(5'd4, 16'd100);
		@(posedge ref_clk_i);
		#1;
		chk("number clash event", {25'h0, ev_code, ev_sess}, 32'h24);
		rd(`MPX_A_SSTAT, v);
		chk("newest excluded", 32'(v[1]), 32'h1);
		wr(`MPX_A_RSV1, 32'h1fef_0034);
		addpid(5'd1, 3'd0, 13'h0200);
		chk("pool exhausted event", {25'h0, ev_code, ev_sess}, 32'h41);
		chk("pool exhausted flag", 32'(v[2]), 32'h1);
		rd(`MPX_A_SSTAT, v);
		chk("exhausted excluded", 32'(v[1]), 32'h1);
		wr(`MPX_A_SEL, 32'h0);
		wr(`MPX_A_CMD, 32'h2);
		pkt(5'd0, 13'h0100, 1'b0, 13'h0);
		rd(`MPX_A_SSTAT, v);
		chk("torn down", v, 32'h0064_0200);
		chk("pat version after teardown", 32'(pat_ver_o), 32'h7);
		tally_and_finish;
	end
	initial begin
		#(100 * 20000);
		mismatches++;
		tally_and_finish;
	end
endmodule
bind mpx_program_mux mpx_program_mux_asserts i_mpx_program_mux_asserts (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.pkt_valid_i(pkt_valid_i), .out_valid_o(out_valid_o), .out_pid_o(out_pid_o),
	.out_drop_o(out_drop_o), .evt_valid_o(evt_valid_o), .evt_code_o(evt_code_o),
	.evt_sess_o(evt_sess_o), .pat_ver_o(pat_ver_o));
`default_nettype wire
